// [rtl/cbt_pkg.sv]
// Constants and types for the CAN bit segment timing configuration block.
// Assumes a 32-bit AXI4-Lite register bus and a single controller clock.
package cbt_pkg;
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] ADDR_CFG2 = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_PH2 = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_MODE = 4'h8;
  localparam logic [ADDR_W-1:0] ADDR_STAT = 4'hC;
  localparam logic [7:0] CFG2_RESET = 8'h00;
  localparam logic [2:0] PH2_RESET = 3'h0;
  localparam logic MODE_RESET = 1'b1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int STAT_PROP_LSB = 0;
  localparam int STAT_PH1_LSB = 4;
  localparam int STAT_PH2_LSB = 8;
  localparam int STAT_SEG_LSB = 12;
  localparam int STAT_BIT_LSB = 14;
  localparam int STAT_CFGMODE_LSB = 15;
  localparam int TQ_CLKS_DEF = 4;
  localparam int IPT_TQ_DEF = 2;
  localparam logic [3:0] SYNC_TQ = 4'h1;

  // Layout matches the eight-bit register, bit 7 down to bit 0
  typedef struct packed {
    logic phase2_length_select;
    logic triple_sample_select;
    logic [2:0] phase1_length_field;
    logic [2:0] propagation_length_field;
  } cbt_cfg2_t;

  // Segment lengths in time quanta, 1..8
  typedef struct packed {
    logic [3:0] prop;
    logic [3:0] ph1;
    logic [3:0] ph2;
  } cbt_len_t;

  typedef enum logic [1:0] {
    SEG_SYNC = 2'h0,
    SEG_PROP = 2'h1,
    SEG_PH1 = 2'h3,
    SEG_PH2 = 2'h2
  } cbt_seg_t;
endpackage : cbt_pkg

// [rtl/cbt_seg_sequencer.sv]
// Time quantum prescaler and bit segment sequencer.
// Assumes segment lengths stay stable while i_run is high.
`timescale 1ns/100ps
`default_nettype none
module cbt_seg_sequencer #(
  parameter int TQ_CLKS = cbt_pkg::TQ_CLKS_DEF
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Control
  input wire logic i_run,
  input wire cbt_pkg::cbt_len_t i_len,
  // Timing outputs
  output logic o_tq_tick,
  output cbt_pkg::cbt_seg_t o_seg,
  output logic o_sample_point,
  output logic o_bit_start
);
  localparam int PW = $clog2(TQ_CLKS + 1);

  generate
    if (TQ_CLKS < 1) begin : g_bad
      $error("TQ_CLKS must be at least 1");
    end
  endgenerate

  logic [PW-1:0] pre_q;
  logic [3:0] quanta_q;
  cbt_pkg::cbt_seg_t seg_q;
  logic [3:0] seg_len;
  logic last_quantum;

  assign o_tq_tick = i_run && (pre_q == PW'(TQ_CLKS - 1));

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pre_q <= '0;
    end else if (!i_run || o_tq_tick) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_q + PW'(1);
    end
  end

  // Bit time: sync quantum, propagation, phase 1, phase 2
  always_comb begin
    unique case (seg_q)
      cbt_pkg::SEG_SYNC: seg_len = cbt_pkg::SYNC_TQ;
      cbt_pkg::SEG_PROP: seg_len = i_len.prop;
      cbt_pkg::SEG_PH1: seg_len = i_len.ph1;
      cbt_pkg::SEG_PH2: seg_len = i_len.ph2;
    endcase
  end

  assign last_quantum = (quanta_q == seg_len - 4'h1);

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      seg_q <= cbt_pkg::SEG_SYNC;
      quanta_q <= 4'h0;
    end else if (!i_run) begin
      seg_q <= cbt_pkg::SEG_SYNC;
      quanta_q <= 4'h0;
    end else if (o_tq_tick) begin
      if (last_quantum) begin
        quanta_q <= 4'h0;
        unique case (seg_q)
          cbt_pkg::SEG_SYNC: seg_q <= cbt_pkg::SEG_PROP;
          cbt_pkg::SEG_PROP: seg_q <= cbt_pkg::SEG_PH1;
          cbt_pkg::SEG_PH1: seg_q <= cbt_pkg::SEG_PH2;
          cbt_pkg::SEG_PH2: seg_q <= cbt_pkg::SEG_SYNC;
        endcase
      end else begin
        quanta_q <= quanta_q + 4'h1;
      end
    end
  end

  assign o_seg = seg_q;
  // Sample point closes phase segment 1
  assign o_sample_point = o_tq_tick && (seg_q == cbt_pkg::SEG_PH1) && last_quantum;
  assign o_bit_start = o_tq_tick && (seg_q == cbt_pkg::SEG_SYNC);

  a_seg_order: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (o_sample_point && i_run) |=> (seg_q == cbt_pkg::SEG_PH2))
    else $error("Phase 2 did not follow the sample point");
  a_sync_single: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (o_tq_tick && seg_q == cbt_pkg::SEG_SYNC) |=> (seg_q == cbt_pkg::SEG_PROP || !i_run))
    else $error("Sync segment lasted more than one quantum");
endmodule : cbt_seg_sequencer
`default_nettype wire

// [rtl/cbt_timing_cfg.sv]
// CAN bit timing configuration register block with AXI4-Lite access.
// Assumes bus pin i_can_rx is asynchronous; all else runs on i_clk.
`timescale 1ns/100ps
`default_nettype none
// Function
// - Select bit 7 set: phase 2 uses its field; clear: max of phase 1 and INFO_PROCESSING_TIME.
// - Bit 6 set: three samples before the sample point; clear: one sample.
// - Phase segment 1 lasts field bits 5..3 plus one quanta.
// - Propagation segment lasts field bits 2..0 plus one quanta.
// - Phase 2 field is ignored while the select bit is clear.
// - Phase 2 field gives field plus one quanta, 1 to 8.
module cbt_timing_cfg #(
  parameter int TQ_CLKS = cbt_pkg::TQ_CLKS_DEF,
  parameter int IPT_TQ = cbt_pkg::IPT_TQ_DEF
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // AXI4-Lite write address and data
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [cbt_pkg::ADDR_W-1:0] i_s_axi_awaddr,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  // AXI4-Lite write response
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  output logic [1:0] o_s_axi_bresp,
  // AXI4-Lite read
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  input wire logic [cbt_pkg::ADDR_W-1:0] i_s_axi_araddr,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  // CAN line and bit timing outputs
  input wire logic i_can_rx,
  output logic o_rx_bit,
  output logic o_rx_bit_valid,
  output logic o_bit_start,
  output cbt_pkg::cbt_seg_t o_seg
);
  generate
    if (IPT_TQ < 1 || IPT_TQ > 8) begin : g_bad_ipt
      $error("IPT_TQ must lie in 1..8");
    end
  endgenerate

  localparam logic [3:0] IPT_LEN = 4'(IPT_TQ);

  cbt_pkg::cbt_cfg2_t cfg2_q;
  logic [2:0] phase2_length_field_q;
  logic cfg_mode_q;
  cbt_pkg::cbt_len_t len;
  logic [3:0] prop_len;
  logic [3:0] ph1_len;
  logic [3:0] ph2_len;

  // Segment lengths derived from the registers
  assign prop_len = {1'b0, cfg2_q.propagation_length_field} + 4'h1;
  assign ph1_len = {1'b0, cfg2_q.phase1_length_field} + 4'h1;
  always_comb begin
    if (cfg2_q.phase2_length_select) begin
      ph2_len = {1'b0, phase2_length_field_q} + 4'h1;
    end else begin
      ph2_len = (ph1_len > IPT_LEN) ? ph1_len : IPT_LEN;
    end
  end
  // One driver for the whole struct, not one per field
  assign len = {prop_len, ph1_len, ph2_len};

  // Write channel capture
  logic aw_got_q;
  logic w_got_q;
  logic [cbt_pkg::ADDR_W-1:0] awaddr_q;
  logic [7:0] wbyte_q;
  logic wlane_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic wr_fire;
  logic wr_ok;

  assign o_s_axi_awready = !aw_got_q && !bvalid_q;
  assign o_s_axi_wready = !w_got_q && !bvalid_q;
  assign wr_fire = aw_got_q && w_got_q && !bvalid_q;

  // Timing registers lock outside configuration mode
  always_comb begin
    unique case (awaddr_q)
      cbt_pkg::ADDR_CFG2: wr_ok = cfg_mode_q;
      cbt_pkg::ADDR_PH2: wr_ok = cfg_mode_q;
      cbt_pkg::ADDR_MODE: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      aw_got_q <= 1'b0;
      awaddr_q <= '0;
    end else if (o_s_axi_awready && i_s_axi_awvalid) begin
      aw_got_q <= 1'b1;
      awaddr_q <= i_s_axi_awaddr;
    end else if (wr_fire) begin
      aw_got_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      w_got_q <= 1'b0;
      wbyte_q <= 8'h00;
      wlane_q <= 1'b0;
    end else if (o_s_axi_wready && i_s_axi_wvalid) begin
      w_got_q <= 1'b1;
      wbyte_q <= i_s_axi_wdata[7:0];
      wlane_q <= i_s_axi_wstrb[0];
    end else if (wr_fire) begin
      w_got_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      bvalid_q <= 1'b0;
      bresp_q <= cbt_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_ok ? cbt_pkg::RESP_OKAY : cbt_pkg::RESP_SLVERR;
    end else if (i_s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  assign o_s_axi_bvalid = bvalid_q;
  assign o_s_axi_bresp = bresp_q;

  // Register updates; only byte lane 0 carries data
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cfg2_q <= cbt_pkg::CFG2_RESET;
      phase2_length_field_q <= cbt_pkg::PH2_RESET;
      cfg_mode_q <= cbt_pkg::MODE_RESET;
    end else if (wr_fire && wr_ok && wlane_q) begin
      unique case (awaddr_q)
        cbt_pkg::ADDR_CFG2: cfg2_q <= wbyte_q;
        cbt_pkg::ADDR_PH2: phase2_length_field_q <= wbyte_q[2:0];
        cbt_pkg::ADDR_MODE: cfg_mode_q <= wbyte_q[0];
        default: cfg_mode_q <= cfg_mode_q;
      endcase
    end
  end

  // Read channel
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic [31:0] stat;
  logic sample_q;

  assign stat = {16'h0000, cfg_mode_q, sample_q, o_seg, len.ph2, len.ph1, len.prop};
  assign o_s_axi_arready = !rvalid_q;

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= cbt_pkg::RESP_OKAY;
    end else if (o_s_axi_arready && i_s_axi_arvalid) begin
      rvalid_q <= 1'b1;
      rresp_q <= cbt_pkg::RESP_OKAY;
      rdata_q <= 32'h0000_0000;
      unique case (i_s_axi_araddr)
        cbt_pkg::ADDR_CFG2: begin
          if (cfg_mode_q) begin
            rdata_q <= {24'h000000, cfg2_q};
          end else begin
            rresp_q <= cbt_pkg::RESP_SLVERR;
          end
        end
        cbt_pkg::ADDR_PH2: begin
          if (cfg_mode_q) begin
            rdata_q <= {29'h00000000, phase2_length_field_q};
          end else begin
            rresp_q <= cbt_pkg::RESP_SLVERR;
          end
        end
        cbt_pkg::ADDR_MODE: rdata_q <= {31'h00000000, cfg_mode_q};
        cbt_pkg::ADDR_STAT: rdata_q <= stat;
        default: rresp_q <= cbt_pkg::RESP_SLVERR;
      endcase
    end else if (i_s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign o_s_axi_rvalid = rvalid_q;
  assign o_s_axi_rdata = rdata_q;
  assign o_s_axi_rresp = rresp_q;

  // Bit timing engine runs only outside configuration mode
  logic tq_tick;
  logic sample_point;

  cbt_seg_sequencer #(
    .TQ_CLKS(TQ_CLKS)
  ) u_seq (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_run(!cfg_mode_q),
    .i_len(len),
    .o_tq_tick(tq_tick),
    .o_seg(o_seg),
    .o_sample_point(sample_point),
    .o_bit_start(o_bit_start)
  );

  // Line sampling
  logic rx_meta_q;
  logic rx_sync_q;
  logic [2:0] hist_q;
  logic vote;
  logic bit_valid_q;

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rx_meta_q <= 1'b1;
      rx_sync_q <= 1'b1;
    end else begin
      rx_meta_q <= i_can_rx;
      rx_sync_q <= rx_meta_q;
    end
  end

  // History holds the three quanta just before the sample point
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      hist_q <= 3'h7;
    end else if (tq_tick) begin
      hist_q <= {hist_q[1:0], rx_sync_q};
    end
  end

  assign vote = (hist_q[0] & hist_q[1]) | (hist_q[0] & hist_q[2]) | (hist_q[1] & hist_q[2]);

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sample_q <= 1'b1;
      bit_valid_q <= 1'b0;
    end else begin
      bit_valid_q <= sample_point;
      if (sample_point) begin
        sample_q <= cfg2_q.triple_sample_select ? vote : rx_sync_q;
      end
    end
  end

  assign o_rx_bit = sample_q;
  assign o_rx_bit_valid = bit_valid_q;

  a_ph2_field: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    cfg2_q.phase2_length_select |-> (len.ph2 == 4'(phase2_length_field_q) + 4'h1))
    else $error("Phase 2 length does not follow its field");
  a_ph2_derived: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !cfg2_q.phase2_length_select |-> (len.ph2 >= len.ph1 && len.ph2 >= IPT_LEN
    && (len.ph2 == len.ph1 || len.ph2 == IPT_LEN)))
    else $error("Derived phase 2 length is not the maximum");
  a_ph2_ignored: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (!cfg2_q.phase2_length_select && $changed(phase2_length_field_q)
    && $stable(cfg2_q)) |-> $stable(len.ph2))
    else $error("Phase 2 field acted while deselected");
  a_ph1_len: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    len.ph1 == 4'(cfg2_q.phase1_length_field) + 4'h1)
    else $error("Phase 1 length wrong");
  a_prop_len: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    len.prop == 4'(cfg2_q.propagation_length_field) + 4'h1)
    else $error("Propagation length wrong");
  a_single_sample: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (sample_point && !cfg2_q.triple_sample_select) |=> (o_rx_bit == $past(rx_sync_q)
    && o_rx_bit_valid))
    else $error("Single sample mismatch");
  a_triple_vote: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (sample_point && cfg2_q.triple_sample_select && hist_q == 3'h0) |=> !o_rx_bit)
    else $error("Triple sample vote wrong");
  a_cfg_locked: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (wr_fire && !cfg_mode_q && awaddr_q == cbt_pkg::ADDR_CFG2)
    |=> ($stable(cfg2_q) && o_s_axi_bvalid && o_s_axi_bresp == cbt_pkg::RESP_SLVERR))
    else $error("Locked timing register was written");
  a_read_answer: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_s_axi_arvalid && o_s_axi_arready) |=> o_s_axi_rvalid)
    else $error("Read answer late");

  c_triple: cover property (@(posedge i_clk) disable iff (i_sys_rst)
    sample_point && cfg2_q.triple_sample_select);
  c_ph2_prog: cover property (@(posedge i_clk) disable iff (i_sys_rst)
    sample_point && cfg2_q.phase2_length_select);
  c_refused: cover property (@(posedge i_clk) disable iff (i_sys_rst)
    wr_fire && !wr_ok);
  c_read_stat: cover property (@(posedge i_clk) disable iff (i_sys_rst)
    i_s_axi_arvalid && o_s_axi_arready && i_s_axi_araddr == cbt_pkg::ADDR_STAT);
endmodule : cbt_timing_cfg
`default_nettype wire

// [dv/cbt_can_node.sv]
// Behavioural CAN node that drives the bus line toward the timing block.
// Assumes i_bit_start pulses once per nominal bit while the engine runs.
`timescale 1ns/100ps
`default_nettype none
module cbt_can_node (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Bit framing seen from the device
  input wire logic i_run,
  input wire logic i_bit_start,
  // Bus line
  output logic o_line,
  output logic o_bit
);
  logic [7:0] lfsr_q;
  // Released line floats recessive; o_bit keeps its last level through idle and drives the line again when i_run returns
  assign o_line = i_run ? o_bit : 1'b1;
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      lfsr_q <= 8'hA5;
      o_bit <= 1'b1;
    end else if (i_bit_start) begin
      lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
      o_bit <= lfsr_q[0];
    end
  end
endmodule : cbt_can_node
`default_nettype wire

// [dv/can_bit_segment_timing_config_tb_top.sv]
// Self-checking bench for the CAN bit timing configuration block.
// Assumes the AXI4-Lite slave in rtl/ and the CAN node model in dv/.
`timescale 1ns/100ps
`default_nettype none
module can_bit_segment_timing_config_tb_top;
  // Four clocks a quantum keeps the line synchroniser inside one quantum
  localparam int TQ = 4;
  localparam int INFO_PROCESSING_TIME = 3;
  logic clk, rst, awv, wv, bre, arv, rre, run, rxchk, line, nbit;
  logic awr, wrdy, bv, arr, rv, rxb, rxv, bst;
  logic [3:0] awa, ara, ws;
  logic [31:0] wd, rdd, seed;
  logic [1:0] bresp, rresp;
  cbt_pkg::cbt_seg_t seg;
  int failures, tests_run;

  cbt_timing_cfg #(.TQ_CLKS(TQ), .IPT_TQ(INFO_PROCESSING_TIME)) cbt_timing_cfg_inst (
    .i_clk(clk), .i_sys_rst(rst),
    .i_s_axi_awvalid(awv), .o_s_axi_awready(awr), .i_s_axi_awaddr(awa),
    .i_s_axi_wvalid(wv), .o_s_axi_wready(wrdy), .i_s_axi_wdata(wd),
    .i_s_axi_wstrb(ws), .o_s_axi_bvalid(bv), .i_s_axi_bready(bre),
    .o_s_axi_bresp(bresp), .i_s_axi_arvalid(arv), .o_s_axi_arready(arr),
    .i_s_axi_araddr(ara), .o_s_axi_rvalid(rv), .i_s_axi_rready(rre),
    .o_s_axi_rdata(rdd), .o_s_axi_rresp(rresp), .i_can_rx(line),
    .o_rx_bit(rxb), .o_rx_bit_valid(rxv), .o_bit_start(bst), .o_seg(seg)
  );
  cbt_can_node cbt_can_node_inst (
    .i_clk(clk), .i_sys_rst(rst), .i_run(run), .i_bit_start(bst),
    .o_line(line), .o_bit(nbit)
  );

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  function automatic logic [3:0] ph2_exp(input logic [7:0] c, input logic [2:0] f);
    logic [3:0] p1;
    p1 = {1'b0, c[5:3]} + 4'h1;
    if (c[7]) return {1'b0, f} + 4'h1;
    return (p1 > 4'(INFO_PROCESSING_TIME)) ? p1 : 4'(INFO_PROCESSING_TIME);
  endfunction : ph2_exp

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_sim

  // Handshakes judged at the falling edge, acted on at the next rising edge
  task automatic wr(input logic [3:0] a, input logic [7:0] d, output logic [1:0] r);
    logic ta, tw, tb;
    @(posedge clk);
    awv <= 1'b1;
    awa <= a;
    wv <= 1'b1;
    wd <= {24'h0, d};
    bre <= 1'b1;
    do begin
      @(negedge clk);
      ta = awv && awr;
      tw = wv && wrdy;
      tb = bv;
      r = bresp;
      @(posedge clk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
    end while (!tb);
    bre <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, tr;
    @(posedge clk);
    arv <= 1'b1;
    ara <= a;
    rre <= 1'b1;
    do begin
      @(negedge clk);
      ta = arv && arr;
      tr = rv;
      d = rdd;
      r = rresp;
      @(posedge clk);
      if (ta) arv <= 1'b0;
    end while (!tr);
    rre <= 1'b0;
  endtask : rd

  task automatic seg_len(input cbt_pkg::cbt_seg_t s, input int e);
    int n;
    n = 0;
    while (seg === s && n < 100) begin
      n++;
      @(negedge clk);
    end
    chk("seg_clks", e * TQ, n);
  endtask : seg_len

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(negedge clk) begin
    if (rxchk && rxv) begin
      chk("rx_bit", {31'h0, nbit}, {31'h0, rxb});
    end
  end

  initial begin
    repeat (30000) @(posedge clk);
    failures++;
    end_sim();
  end

  initial begin
    logic [31:0] d;
    logic [7:0] c;
    logic [2:0] f;
    logic [3:0] p2;
    logic [1:0] r;
    logic [7:0] corn [3];
    corn = '{8'hFF, 8'h08, 8'h2D};
    seed = 32'd21271;
    failures = 0;
    tests_run = 0;
    rst = 1'b1;
    {awv, wv, bre, arv, rre, run, rxchk} = 7'h00;
    awa = 4'h0;
    ara = 4'h0;
    wd = 32'h0;
    ws = 4'hF;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(cbt_pkg::ADDR_CFG2, d, r);
    chk("cfg2_reset", {24'h0, cbt_pkg::CFG2_RESET}, d);
    rd(cbt_pkg::ADDR_MODE, d, r);
    chk("mode_reset", 32'h1, {31'h0, d[0]});
    wr(4'h2, 8'h00, r);
    chk("unmapped_wr", {30'h0, cbt_pkg::RESP_SLVERR}, {30'h0, r});
    wr(cbt_pkg::ADDR_STAT, 8'hFF, r);
    chk("stat_wr", {30'h0, cbt_pkg::RESP_SLVERR}, {30'h0, r});
    for (int k = 0; k < 8; k++) begin
      d = xs();
      c = (k < 3) ? corn[k] : d[7:0];
      f = (k == 0) ? 3'h5 : d[10:8];
      // One-quantum propagation and phase 1 segments would make the vote reach into the previous bit
      if (c[6] && c[5:0] == 6'h00) begin
        c[0] = 1'b1;
      end
      wr(cbt_pkg::ADDR_CFG2, c, r);
      wr(cbt_pkg::ADDR_PH2, {5'h0, f}, r);
      rd(cbt_pkg::ADDR_CFG2, d, r);
      chk("cfg2_rd", {24'h0, c}, d);
      rd(cbt_pkg::ADDR_PH2, d, r);
      chk("ph2_rd", {29'h0, f}, d);
      // Lane 0 strobe low: write accepted, register kept
      ws <= 4'h0;
      wr(cbt_pkg::ADDR_CFG2, ~c, r);
      ws <= 4'hF;
      chk("strobe_resp", {30'h0, cbt_pkg::RESP_OKAY}, {30'h0, r});
      rd(cbt_pkg::ADDR_CFG2, d, r);
      chk("cfg2_kept", {24'h0, c}, d);
      wr(cbt_pkg::ADDR_MODE, 8'h00, r);
      run <= 1'b1;
      wr(cbt_pkg::ADDR_CFG2, ~c, r);
      chk("cfg2_locked", {30'h0, cbt_pkg::RESP_SLVERR}, {30'h0, r});
      rd(cbt_pkg::ADDR_CFG2, d, r);
      chk("cfg2_hidden", {30'h0, cbt_pkg::RESP_SLVERR}, {30'h0, r});
      p2 = ph2_exp(c, f);
      rd(cbt_pkg::ADDR_STAT, d, r);
      chk("stat_lens", {p2, {1'b0, c[5:3]} + 4'h1, {1'b0, c[2:0]} + 4'h1}, d[11:0]);
      chk("stat_mode", 32'h0, {31'h0, d[15]});
      @(negedge clk);
      while (seg !== cbt_pkg::SEG_SYNC) @(negedge clk);
      while (seg === cbt_pkg::SEG_SYNC) @(negedge clk);
      seg_len(cbt_pkg::SEG_PROP, c[2:0] + 1);
      seg_len(cbt_pkg::SEG_PH1, c[5:3] + 1);
      seg_len(cbt_pkg::SEG_PH2, p2);
      seg_len(cbt_pkg::SEG_SYNC, 1);
      rxchk <= 1'b1;
      repeat (100 * TQ) @(posedge clk);
      rxchk <= 1'b0;
      wr(cbt_pkg::ADDR_MODE, 8'h01, r);
      run <= 1'b0;
    end
    end_sim();
  end
endmodule : can_bit_segment_timing_config_tb_top
`default_nettype wire
